// ---- inc/far_pkg.sv ----
// fault alarm reporter package: error classes, analog level codes, timing
// assumes a 100 MHz sys_clk and a 10-bit dac code for 0..10 v full scale
package far_pkg;
  localparam int unsigned CODE_W = 10; // error code as binary value 0..999
  localparam int unsigned DAC_W = 10; // output dac code width
  localparam int unsigned CLK_HZ = 100_000_000; // system clock rate
  localparam int unsigned TOGGLE_HZ = 2; // half periods per second for 1 hz blink
  localparam int unsigned HALF_CYC = CLK_HZ / TOGGLE_HZ; // cycles per half period
  localparam int unsigned CNT_W = 26; // width of the half-period counter
  // dac codes, 1023 counts = 10 v
  localparam logic [DAC_W-1:0] LVL_0V66 = 10'h43;
  localparam logic [DAC_W-1:0] LVL_1V33 = 10'h88;
  localparam logic [DAC_W-1:0] LVL_2V00 = 10'hcd;
  localparam logic [DAC_W-1:0] LVL_2V66 = 10'h110;
  localparam logic [DAC_W-1:0] LVL_3V33 = 10'h155;
  localparam logic [DAC_W-1:0] LVL_4V00 = 10'h199;
  localparam logic [DAC_W-1:0] LVL_4V66 = 10'h1dc;
  localparam logic [DAC_W-1:0] LVL_5V33 = 10'h221;
  localparam logic [DAC_W-1:0] LVL_6V00 = 10'h266;
  localparam logic [DAC_W-1:0] LVL_6V66 = 10'h2a9;
  localparam logic [DAC_W-1:0] LVL_7V33 = 10'h2ee;
  localparam logic [DAC_W-1:0] LVL_8V00 = 10'h333;
  localparam logic [DAC_W-1:0] LVL_FULL = 10'h3ff;
  localparam logic [CODE_W-1:0] CODE_NONE = 10'h000;
  // error code values
  localparam logic [CODE_W-1:0] E101 = 10'h065;
  localparam logic [CODE_W-1:0] E102 = 10'h066;
  localparam logic [CODE_W-1:0] E103 = 10'h067;
  localparam logic [CODE_W-1:0] E104 = 10'h068;
  localparam logic [CODE_W-1:0] E105 = 10'h069;
  localparam logic [CODE_W-1:0] E106 = 10'h06a;
  localparam logic [CODE_W-1:0] E107 = 10'h06b;
  localparam logic [CODE_W-1:0] E108 = 10'h06c;
  localparam logic [CODE_W-1:0] E111 = 10'h06f;
  localparam logic [CODE_W-1:0] E112 = 10'h070;
  localparam logic [CODE_W-1:0] E113 = 10'h071;
  localparam logic [CODE_W-1:0] E201 = 10'h0c9;
  localparam logic [CODE_W-1:0] E203 = 10'h0cb;
  localparam logic [CODE_W-1:0] E211 = 10'h0d3;
  localparam logic [CODE_W-1:0] E801 = 10'h321;
  localparam logic [CODE_W-1:0] E900 = 10'h384;
  localparam logic [CODE_W-1:0] E999 = 10'h3e7;
  // alarm classes
  typedef enum logic [1:0] {FAR_CLS_NONE, FAR_CLS_FAULT, FAR_CLS_CAL} far_cls_e;
endpackage

// ---- rtl/far_blink.sv ----
// fault alarm reporter blink timer: toggles a phase bit every half second
// assumes sys_clk at 100 mhz and that run drops when blinking must stop
`timescale 1ns/1ps
module far_blink
  import far_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic run, // count only while high
  output logic phase // high during the full-scale half
);
  logic [CNT_W-1:0] cnt; // half-period counter
  logic [CNT_W-1:0] next_cnt;
  logic next_phase;

  // next count and phase; restart cleanly whenever run is low
  always_comb
  begin
    next_cnt = cnt;
    next_phase = phase;
    if (!run)
    begin
      next_cnt = '0;
      next_phase = 1'b0;
    end
    else if (cnt == CNT_W'(HALF_CYC - 1))
    begin
      next_cnt = '0;
      next_phase = ~phase;
    end
    else
    begin
      next_cnt = cnt + CNT_W'(1);
    end
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      phase <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end
endmodule // far_blink

// ---- rtl/far_reporter.sv ----
// fault alarm reporter: latches an error code, shows it, drives the alarm
// contact and replaces the actual-value dac code by a coded error level.
// assumes fault detection supplies a code with a one-cycle valid strobe and
// that all inputs are synchronous to sys_clk.
`timescale 1ns/1ps
// Function
// - factory: calibration class errors open contact
// - start closes contact during calibration error
// - factory: fault class errors close contact
// - non-factory polarity inverts contact state
// - fault codes map to fixed analog levels
// - calibration errors blink level/full scale 1hz
// - start freezes blinking output level
// - alarm latched until reset key or power
// - display shows latched error code
module far_reporter
  import far_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n, // power-on reset
  input wire logic clk_en, // freezes all state while low
  input wire logic err_valid, // one-cycle strobe: new error detected
  input wire logic [far_pkg::CODE_W-1:0] err_code, // binary error code
  input wire logic start_req, // start signal level
  input wire logic reset_key, // operator reset key level
  input wire logic relay_inverted, // high: non-factory alarm relay polarity
  input wire logic [far_pkg::DAC_W-1:0] temp_level, // normal temperature dac code
  output logic alarm_active, // alarm latched
  output logic [far_pkg::CODE_W-1:0] disp_code, // code for the display
  output logic contact_closed, // alarm contact closed
  output logic [far_pkg::DAC_W-1:0] act_out // actual-value output dac code
);
  import far_pkg::*;

  far_cls_e cls; // class of the latched error
  far_cls_e next_cls;
  logic [CODE_W-1:0] code; // latched code
  logic [CODE_W-1:0] next_code;
  logic frozen; // start seen during a calibration error
  logic next_frozen;
  logic [DAC_W-1:0] frz_level; // level held after freeze
  logic [DAC_W-1:0] next_frz_level;
  logic phase; // blink phase, high shows full scale
  logic [DAC_W-1:0] err_level; // level for the latched code
  logic [DAC_W-1:0] blink_level; // level as currently blinking
  logic open_factory; // contact open in factory polarity
  logic [DAC_W-1:0] next_act;
  logic next_contact;
  far_cls_e in_cls; // class of the incoming code

  // classify an incoming code; unknown codes are treated as faults
  always_comb
  begin
    if ((err_code >= E104 && err_code <= E106) || (err_code >= E111 && err_code <= E113)
        || err_code == E211)
      in_cls = FAR_CLS_CAL;
    else
      in_cls = FAR_CLS_FAULT;
  end

  // map the latched code to its level
  always_comb
  begin
    if (code == E101)
      err_level = LVL_0V66;
    else if (code == E102)
      err_level = LVL_1V33;
    else if (code == E103)
      err_level = LVL_2V00;
    else if (code == E107 || code == E108)
      err_level = LVL_2V66;
    else if (code >= E201 && code <= E203)
      err_level = LVL_3V33;
    else if (code == E801)
      err_level = LVL_4V00;
    else if (code >= E900 && code <= E999)
      err_level = LVL_4V66;
    else if (code >= E104 && code <= E106)
      err_level = LVL_5V33;
    else if (code == E211)
      err_level = LVL_6V00;
    else if (code == E111)
      err_level = LVL_6V66;
    else if (code == E112)
      err_level = LVL_7V33;
    else if (code == E113)
      err_level = LVL_8V00;
    else
      err_level = LVL_4V66; // unlisted code: shown as internal fault
  end

  // blink timer runs only while an unfrozen calibration error is latched
  far_blink u_blink (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(cls == FAR_CLS_CAL && !frozen),
    .phase(phase)
  );

  assign blink_level = phase ? LVL_FULL : err_level;

  // alarm latch: the first error is kept, only reset key or power clears it
  always_comb
  begin
    next_cls = cls;
    next_code = code;
    next_frozen = frozen;
    next_frz_level = frz_level;
    case (cls)
      FAR_CLS_NONE:
      begin
        // a new error beats a held reset key so no event is lost
        if (err_valid)
        begin
          next_cls = in_cls;
          next_code = err_code;
        end
      end
      default:
      begin
        if (reset_key)
        begin
          // reset key is the only clearing path short of power-up
          next_cls = FAR_CLS_NONE;
          next_code = CODE_NONE;
          next_frozen = 1'b0;
        end
        else if (cls == FAR_CLS_CAL && start_req && !frozen)
        begin
          // keep whatever level is showing at this moment
          next_frozen = 1'b1;
          next_frz_level = blink_level;
        end
      end
    endcase
  end

  // output values; contact idle state is open in factory polarity
  always_comb
  begin
    next_act = temp_level;
    open_factory = 1'b1;
    case (cls)
      FAR_CLS_FAULT:
      begin
        next_act = err_level;
        open_factory = 1'b0;
      end
      FAR_CLS_CAL:
      begin
        next_act = frozen ? frz_level : blink_level;
        open_factory = !frozen;
      end
      default:
      begin
        next_act = temp_level;
        open_factory = 1'b1;
      end
    endcase
    next_contact = relay_inverted ? open_factory : !open_factory;
  end

  // state and output registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cls <= FAR_CLS_NONE;
      code <= CODE_NONE;
      frozen <= 1'b0;
      frz_level <= '0;
      act_out <= '0;
      contact_closed <= 1'b0;
    end
    else if (clk_en)
    begin
      cls <= next_cls;
      code <= next_code;
      frozen <= next_frozen;
      frz_level <= next_frz_level;
      act_out <= next_act;
      contact_closed <= next_contact;
    end
  end

  assign alarm_active = (cls != FAR_CLS_NONE);
  assign disp_code = code;
endmodule // far_reporter

// ---- bench/far_checker.sv ----
// checker: output timing of the reporter against its inputs
// assumes relay_inverted moves only while idle; frozen cycles (clk_en low) are not checked
`timescale 1ns/1ps
module far_checker
  import far_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic err_valid,
  input wire logic [far_pkg::CODE_W-1:0] err_code,
  input wire logic start_req,
  input wire logic reset_key,
  input wire logic relay_inverted,
  input wire logic [far_pkg::DAC_W-1:0] temp_level,
  input wire logic alarm_active,
  input wire logic [far_pkg::CODE_W-1:0] disp_code,
  input wire logic contact_closed,
  input wire logic [far_pkg::DAC_W-1:0] act_out
);
  default clocking cb @(posedge sys_clk); endclocking
  // a frozen cycle moves no state, so timing checks would misfire there
  default disable iff (!rst_n || !clk_en);
  // calibration class: contact open and output blinking
  function automatic logic is_cal(input logic [CODE_W-1:0] c);
    return c inside {[E104:E106], [E111:E113], E211};
  endfunction
  // level that each code shows; the full-scale half of a blink is allowed separately
  function automatic logic [DAC_W-1:0] lvl_of(input logic [CODE_W-1:0] c);
    case (c) inside
      E101: return LVL_0V66;
      E102: return LVL_1V33;
      E103: return LVL_2V00;
      E107, E108: return LVL_2V66;
      [E201:E203]: return LVL_3V33;
      E801: return LVL_4V00;
      [E104:E106]: return LVL_5V33;
      E211: return LVL_6V00;
      E111: return LVL_6V66;
      E112: return LVL_7V33;
      E113: return LVL_8V00;
      default: return LVL_4V66;
    endcase
  endfunction
  property p_take; err_valid && !alarm_active |=> alarm_active && disp_code == $past(err_code);
  endproperty
  a_take: assert property (p_take) else $error("code not latched");
  property p_hold; alarm_active && !reset_key |=> alarm_active && $stable(disp_code); endproperty
  a_hold: assert property (p_hold) else $error("alarm lost");
  property p_clear; alarm_active && reset_key |=> !alarm_active; endproperty
  a_clear: assert property (p_clear) else $error("key did not clear");
  // the first edge after release still shows the reset value of act_out
  property p_idle; !alarm_active && $past(rst_n) |=> act_out == $past(temp_level); endproperty
  a_idle: assert property (p_idle) else $error("no temperature out");
  property p_cal_open;
    err_valid && !alarm_active && is_cal(err_code) && !start_req ##1 !start_req
      |=> contact_closed == relay_inverted;
  endproperty
  a_cal_open: assert property (p_cal_open) else $error("cal contact");
  property p_fault;
    alarm_active && $past(alarm_active) && !is_cal(disp_code) |-> contact_closed != relay_inverted;
  endproperty
  a_fault: assert property (p_fault) else $error("fault contact");
  // a reset key in the same window clears the alarm instead
  property p_start;
    alarm_active && is_cal(disp_code) && start_req && !reset_key ##1 !reset_key
      |=> contact_closed != relay_inverted;
  endproperty
  a_start: assert property (p_start) else $error("start contact");
  property p_freeze; alarm_active && is_cal(disp_code) && start_req ##1 alarm_active |=> $stable(act_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  // once outputs have settled, the level matches the latched code or full scale
  property p_level;
    alarm_active && $past(alarm_active)
      |-> act_out == lvl_of(disp_code) || (is_cal(disp_code) && act_out == LVL_FULL);
  endproperty
  a_level: assert property (p_level) else $error("wrong error level");
endmodule // far_checker
bind far_reporter far_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .err_valid(err_valid),
  .err_code(err_code), .start_req(start_req), .reset_key(reset_key),
  .relay_inverted(relay_inverted), .temp_level(temp_level), .alarm_active(alarm_active),
  .disp_code(disp_code), .contact_closed(contact_closed), .act_out(act_out));

// ---- bench/far_operator.sv ----
// operator model: turns bench commands into key and start levels
// assumes commands are raised just after a rising edge
`timescale 1ns/1ps
module far_operator (
  input wire logic sys_clk,
  input wire logic press_reset, // hold the reset key
  input wire logic press_start, // hold the start signal
  output logic reset_key,
  output logic start_req
);
  // levels move only on the edge, so the design never sees a glitch
  always @(posedge sys_clk)
  begin
    reset_key <= press_reset;
    start_req <= press_start;
  end
  initial
  begin
    reset_key = 1'b0;
    start_req = 1'b0;
  end
endmodule // far_operator

// ---- bench/fault_alarm_reporter_bench.sv ----
// bench: every error level in both relay polarities, then reset paths and clock enable
// assumes the operator model and the bound checker
`timescale 1ns/1ps
module fault_alarm_reporter_bench;
  import far_pkg::*;
  typedef struct packed {logic [CODE_W-1:0] code; logic [DAC_W-1:0] lvl; logic cal;} far_row_s;
  // blinking half periods are far beyond the run, so only phase 0 is seen
  far_row_s rows [12] = '{'{E101, LVL_0V66, 1'b0}, '{E102, LVL_1V33, 1'b0},
    '{E103, LVL_2V00, 1'b0}, '{E108, LVL_2V66, 1'b0}, '{E203, LVL_3V33, 1'b0},
    '{E801, LVL_4V00, 1'b0}, '{E999, LVL_4V66, 1'b0}, '{E105, LVL_5V33, 1'b1},
    '{E211, LVL_6V00, 1'b1}, '{E111, LVL_6V66, 1'b1}, '{E112, LVL_7V33, 1'b1},
    '{E113, LVL_8V00, 1'b1}};
  logic sys_clk, rst_n = 0, err_valid = 0, relay_inverted = 0, press_reset = 0, press_start = 0;
  logic clk_en = 1'b1; // low freezes the design
  logic [CODE_W-1:0] err_code = '0;
  logic [DAC_W-1:0] temp_level = 10'h123;
  logic reset_key, start_req, alarm_active, contact_closed;
  logic [CODE_W-1:0] disp_code;
  logic [DAC_W-1:0] act_out;
  int fail_count = 0;
  int checked = 0;
  far_operator op_u (.sys_clk(sys_clk), .press_reset(press_reset), .press_start(press_start),
    .reset_key(reset_key), .start_req(start_req));
  far_reporter dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .err_valid(err_valid),
    .err_code(err_code), .start_req(start_req), .reset_key(reset_key),
    .relay_inverted(relay_inverted), .temp_level(temp_level), .alarm_active(alarm_active),
    .disp_code(disp_code), .contact_closed(contact_closed), .act_out(act_out));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one-cycle strobe, then wait until the dac code has settled
  task raise(input logic [CODE_W-1:0] c);
    cyc(1);
    err_valid <= 1'b1;
    err_code <= c;
    cyc(1);
    err_valid <= 1'b0;
    cyc(2);
    #1;
  endtask
  task clear();
    cyc(1);
    press_reset <= 1'b1;
    cyc(1);
    press_reset <= 1'b0;
    cyc(3);
    #1;
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(3);
    #1;
    chk(alarm_active, 0);
    chk(act_out, temp_level);
    chk(contact_closed, relay_inverted);
    $display("reset done");
    for (int inv = 0; inv < 2; inv++)
      foreach (rows[i])
      begin
        cyc(1);
        relay_inverted <= inv[0];
        temp_level <= DAC_W'(10'h100 + i);
        raise(rows[i].code);
        chk(disp_code, rows[i].code);
        chk(act_out, rows[i].lvl);
        chk(contact_closed, inv[0] ^ !rows[i].cal);
        if (rows[i].cal)
        begin
          cyc(1);
          press_start <= 1'b1;
          cyc(4);
          #1;
          chk(contact_closed, !inv[0]);
          chk(act_out, rows[i].lvl);
          cyc(1);
          press_start <= 1'b0;
        end
        clear();
        chk(alarm_active, 0);
        chk(act_out, temp_level);
        chk(contact_closed, inv[0]);
        $display("row %0d done", i);
      end
    // a second error while latched is ignored, power cycle clears
    raise(E101);
    raise(E801);
    chk(disp_code, E101);
    cyc(1);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
    #1;
    chk(alarm_active, 0);
    chk(disp_code, CODE_NONE);
    chk(act_out, temp_level);
    chk(contact_closed, relay_inverted);
    $display("latch and power cycle done");
    // a strobe in frozen cycles must not be taken; temp_level stays put meanwhile
    cyc(1);
    clk_en <= 1'b0;
    raise(E801);
    cyc(1);
    clk_en <= 1'b1;
    cyc(2);
    #1;
    chk(alarm_active, 1'b0);
    chk(disp_code, CODE_NONE);
    chk(act_out, temp_level);
    $display("clock enable freeze done");
    final_report();
  end
  initial
  begin
    cyc(20000);
    fail_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule // fault_alarm_reporter_bench
